// >>> chan_filter.sv
`timescale 1ns/1ps
`default_nettype none
module chan_filter (
   input  wire logic       ref_clk,
   input  wire logic       reset,
   input  wire logic       enable,
   input  wire logic       tick,
   input  wire logic [6:0] delay_ms,
   input  wire logic       pin_sync,
   output logic            level
);
   import filt_pkg::*;
   logic [6:0] count_reg;

   // Count ticks while the input differs from the output
   always_ff @(posedge ref_clk) begin
      if (reset || !enable) begin
         level     <= 1'b0;
         count_reg <= 7'd0;
      end else if (pin_sync == level) begin
         count_reg <= 7'd0; // Short pulse discarded
      end else if (tick) begin
         if (count_reg + 7'd1 >= delay_ms) begin
            level     <= pin_sync;
            count_reg <= 7'd0;
         end else begin
            count_reg <= count_reg + 7'd1;
         end
      end
   end

   // Count has run out on this tick with the input still away from the output
   sequence s_due;
      enable && tick && (pin_sync != level) && (count_reg + 7'd1 >= delay_ms);
   endsequence

   // Output takes the input level once the delay is used up
   a_switch_due : assert property (@(posedge ref_clk) disable iff (reset)
      s_due |=> (level == $past(pin_sync)))
      else $error("level did not switch when due");

   // Input agreeing with the output never moves it
   a_level_hold : assert property (@(posedge ref_clk) disable iff (reset)
      (enable && (pin_sync == level)) |=> $stable(level))
      else $error("level moved while input agreed");
endmodule // chan_filter
`default_nettype wire

// >>> field_wiring.sv
`timescale 1ns/1ps
`default_nettype none
module field_wiring (
   input  wire logic       ref_clk,
   input  wire logic       start,
   input  wire logic [3:0] pts,
   input  wire logic [15:0] width,
   output logic      [3:0] in_point
);
   logic [15:0] cnt_reg = 16'h0000;
   // Lines go to pts for width cycles after a start strobe, then back off
   always_ff @(posedge ref_clk) begin
      cnt_reg  <= start ? width : cnt_reg - 16'(cnt_reg != 16'h0000);
      in_point <= (start || (cnt_reg > 16'h0001)) ? pts : 4'h0;
   end
endmodule // field_wiring
`default_nettype wire

// >>> filt_pkg.sv
// Behaviour
// - Filter function is on while mode word low byte holds BCD 60.
// - In filter mode all four inputs are plain filtered discrete inputs.
// - Each input has its own delay; filter output is its logical value.
// - Levels longer than delay pass, both edges delayed by that delay.
// - Pulses shorter than the delay are dropped; output stays off.
// - Delay is 10 to 99 ms, two BCD digits in config upper byte.
// - One config word per input, inputs 0 to 3 in consecutive order.
// - Mode upper byte 20 selects power-up-in-run; writes act immediately.
package filt_pkg;
   localparam int          NUM_IN       = 4;
   localparam int          CLK_HZ       = 250_000_000;
   localparam int          TICK_MS      = 1;
   localparam int          TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   localparam logic [7:0]  MODE_FILTER  = 8'h60;
   localparam logic [7:0]  OPT_RUN      = 8'h20;
   localparam logic [7:0]  CFG_FILTER   = 8'h06;
   localparam logic [6:0]  DELAY_MIN    = 7'd10;
   localparam logic [6:0]  DELAY_MAX    = 7'd99;
   localparam logic [15:0] MODE_RESET   = 16'h0000;
   localparam logic [15:0] CFG_RESET    = 16'h1006;
   localparam logic [2:0]  SEL_MODE     = 3'h0;
   localparam logic [2:0]  SEL_CFG0     = 3'h1;

   // One register write from the scanning controller
   typedef struct packed {
      logic        wr;
      logic [2:0]  sel;
      logic [15:0] data;
   } reg_wr_t;
endpackage

// >>> four_channel_input_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module four_channel_input_filter_tb;
   import filt_pkg::*;
   localparam int          TICK_T = 40; // Short tick keeps millisecond delays affordable
   localparam logic [15:0] CFG_V [4] = '{16'h9906, 16'h4506, 16'h2306, 16'h1206};
   localparam int          DLY_V [4] = '{99, 45, 23, 12};
   localparam int          LONG_W = 6000;
   logic        ref_clk = 1'b0, reset = 1'b1, start = 1'b0, filter_on, run_at_powerup;
   logic [2:0]  rd_sel = 3'h0;
   logic [15:0] rd_data, width = 16'd200;
   logic [3:0]  in_point, in_image;
   reg_wr_t     reg_wr = '0;
   int          failures = 0, checked = 0;
   // 250 MHz core clock
   always #2 ref_clk = ~ref_clk;
   four_channel_input_filter #(.TICK_LEN(TICK_T)) i_dut (.ref_clk, .reset, .reg_wr, .rd_sel, .rd_data,
      .in_point, .in_image, .filter_on, .run_at_powerup);
   field_wiring i_field (.ref_clk, .start, .pts(4'hF), .width, .in_point);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Back-to-back calls give one write per edge
   task automatic wr(input logic [2:0] s, input logic [15:0] d);
      @(posedge ref_clk) reg_wr <= '{1'b1, s, d};
   endtask
   task automatic rd(input logic [2:0] s, input logic [15:0] exp);
      @(posedge ref_clk) rd_sel <= s;
      @(posedge ref_clk) #1 check(rd_data, exp);
   endtask
   task automatic flags(input logic [15:0] exp);
      @(posedge ref_clk) reg_wr.wr <= 1'b0;
      @(posedge ref_clk) #1 check({14'h0000, filter_on, run_at_powerup}, exp);
   endtask
   task automatic complete_run;
      $display("Checks %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic t_regs;
      rd(3'h0, 16'h0000);
      for (int i = 1; i < 5; i++) rd(3'(i), CFG_RESET);
      wr(3'h0, 16'h2060);
      for (int i = 0; i < 4; i++) wr(3'(i + 1), CFG_V[i]);
      wr(3'h5, 16'hFFFF);
      flags(16'h0003);
      for (int i = 0; i < 4; i++) rd(3'(i + 1), CFG_V[i]);
      rd(3'h5, 16'h0000);
      wr(3'h0, 16'h0060);
      flags(16'h0002);
      $display("Test registers done");
   endtask
   // Any image bit seen high across the window is a leaked glitch
   task automatic t_glitch;
      logic [3:0] seen;
      seen = 4'h0;
      @(posedge ref_clk) begin
         start <= 1'b1;
         width <= 16'd200;
      end
      @(posedge ref_clk) start <= 1'b0;
      repeat (1000) @(posedge ref_clk) #1 seen |= in_image;
      check({12'h000, seen}, 16'h0000);
      $display("Test glitch done");
   endtask
   // Long level: each channel rises and falls one programmed delay later, within one tick
   task automatic t_level;
      int rise [4];
      int fall [4];
      for (int i = 0; i < 4; i++) begin
         rise[i] = -1;
         fall[i] = -1;
      end
      @(posedge ref_clk) begin
         start <= 1'b1;
         width <= 16'(LONG_W);
      end
      @(posedge ref_clk) start <= 1'b0;
      for (int c = 1; c < 2 * LONG_W; c++) begin
         @(posedge ref_clk) #1;
         for (int i = 0; i < 4; i++) begin
            if (in_image[i] === 1'b1 && rise[i] < 0) rise[i] = c;
            if (in_image[i] === 1'b0 && rise[i] >= 0 && fall[i] < 0) fall[i] = c - LONG_W;
         end
      end
      for (int i = 0; i < 4; i++) begin
         check(16'(rise[i] >= (DLY_V[i] - 1) * TICK_T && rise[i] <= DLY_V[i] * TICK_T + 8), 16'h0001);
         check(16'(fall[i] >= (DLY_V[i] - 1) * TICK_T && fall[i] <= DLY_V[i] * TICK_T + 8), 16'h0001);
      end
      $display("Test level done");
   endtask
   // Outside filter mode a long level never reaches the image
   task automatic t_off;
      logic [3:0] seen;
      seen = 4'h0;
      wr(3'h0, 16'h0050);
      flags(16'h0000);
      @(posedge ref_clk) begin
         start <= 1'b1;
         width <= 16'd2000;
      end
      @(posedge ref_clk) start <= 1'b0;
      repeat (2000) @(posedge ref_clk) #1 seen |= in_image;
      check({12'h000, seen}, 16'h0000);
      wr(3'h0, 16'h0060);
      flags(16'h0002);
      $display("Test mode off done");
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      t_regs;
      t_glitch;
      t_level;
      t_off;
      complete_run;
   end
endmodule // four_channel_input_filter_tb
`default_nettype wire

// >>> input_filter.sv
`timescale 1ns/1ps
`default_nettype none
module four_channel_input_filter #(
   parameter int TICK_LEN = filt_pkg::TICK_CYCLES // Core cycles per 1 ms tick; a bench may shorten it
) (
   input  wire logic                        ref_clk,
   input  wire logic                        reset,
   input  wire filt_pkg::reg_wr_t           reg_wr,
   input  wire logic [2:0]                  rd_sel,
   output logic [15:0]                      rd_data,
   input  wire logic [filt_pkg::NUM_IN-1:0] in_point,
   output logic [filt_pkg::NUM_IN-1:0]      in_image,
   output logic                             filter_on,
   output logic                             run_at_powerup
);
   import filt_pkg::*;

   // Register file, synchroniser, tick divider and decode state
   logic [15:0]       mode_reg;
   logic [15:0]       cfg_reg [NUM_IN];
   logic [NUM_IN-1:0] meta_reg;
   logic [NUM_IN-1:0] sync_reg;
   logic [17:0]       div_reg;
   logic              tick;
   logic [NUM_IN-1:0] level;
   logic              wr_mode;
   logic              wr_cfg;
   logic [1:0]        wr_idx;
   logic [1:0]        rd_idx;

   // BCD byte to binary, clamped; eight bits so bad digits cannot wrap
   function automatic logic [6:0] bcd_delay(input logic [7:0] b);
      logic [7:0] v;
      v = 8'(b[7:4]) * 8'd10 + 8'(b[3:0]);
      if (v < 8'(DELAY_MIN))
         v = 8'(DELAY_MIN);
      if (v > 8'(DELAY_MAX))
         v = 8'(DELAY_MAX);
      return v[6:0];
   endfunction

   // True when a select code addresses one of the input config words
   function automatic logic cfg_hit(input logic [2:0] sel);
      return (sel >= SEL_CFG0) && (sel < SEL_CFG0 + 3'(NUM_IN));
   endfunction

   // Select code to config word index, input 0 first
   function automatic logic [1:0] cfg_index(input logic [2:0] sel);
      logic [2:0] d;
      d = sel - SEL_CFG0;
      return d[1:0];
   endfunction

   // Strobes decoded once, shared by the register process and the checks
   assign wr_mode = reg_wr.wr && (reg_wr.sel == SEL_MODE);
   assign wr_cfg  = reg_wr.wr && cfg_hit(reg_wr.sel);
   assign wr_idx  = cfg_index(reg_wr.sel);
   assign rd_idx  = cfg_index(rd_sel);

   // Register writes take effect on the next edge
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mode_reg <= MODE_RESET;
         for (int i = 0; i < NUM_IN; i++)
            cfg_reg[i] <= CFG_RESET;
      end else if (wr_mode) begin
         mode_reg <= reg_wr.data;
      end else if (wr_cfg) begin
         cfg_reg[wr_idx] <= reg_wr.data;
      end
   end

   // Readback; unmapped selects read zero
   always_ff @(posedge ref_clk) begin
      if (reset)
         rd_data <= 16'h0000;
      else if (rd_sel == SEL_MODE)
         rd_data <= mode_reg;
      else if (cfg_hit(rd_sel))
         rd_data <= cfg_reg[rd_idx];
      else
         rd_data <= 16'h0000;
   end

   // Field pins are asynchronous: two flops first
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= in_point;
         sync_reg <= meta_reg;
      end
   end

   // Millisecond tick divider
   always_ff @(posedge ref_clk) begin
      if (reset || tick)
         div_reg <= 18'd0;
      else
         div_reg <= div_reg + 18'd1;
   end
   assign tick = (div_reg == 18'(TICK_LEN - 1));

   assign filter_on      = (mode_reg[7:0] == MODE_FILTER);
   assign run_at_powerup = (mode_reg[15:8] == OPT_RUN);

   // One filter per input, each with its own delay
   // The tick is shared, so a delay lands up to one tick early: cheaper than four dividers
   for (genvar g = 0; g < NUM_IN; g++) begin : g_ch
      chan_filter u_ch (
         .ref_clk  (ref_clk),
         .reset    (reset),
         .enable   (filter_on),
         .tick     (tick),
         .delay_ms (bcd_delay(cfg_reg[g][15:8])),
         .pin_sync (sync_reg[g]),
         .level    (level[g])
      );
   end

   // Every input is a plain filtered point; no special functions
   always_ff @(posedge ref_clk) begin
      if (reset)
         in_image <= '0;
      else
         in_image <= level;
   end

   // Mode away from filtering
   sequence s_mode_off;
      mode_reg[7:0] != MODE_FILTER;
   endsequence

   // Image empty two edges on
   sequence s_image_clear;
      ##1 (in_image == '0);
   endsequence

   // Mode word written this cycle
   sequence s_mode_write;
      wr_mode;
   endsequence

   // Config word written this cycle
   sequence s_cfg_write;
      wr_cfg;
   endsequence

   // Mode word selected for readback
   sequence s_read_mode;
      rd_sel == SEL_MODE;
   endsequence

   // Config word selected for readback
   sequence s_read_cfg;
      cfg_hit(rd_sel);
   endsequence

   // Leaving filter mode empties the image
   a_mode_enable : assert property (@(posedge ref_clk) disable iff (reset)
      s_mode_off |=> s_image_clear)
      else $error("image not off");

   // Filters only move on a tick or when switched off
   a_no_glitch : assert property (@(posedge ref_clk) disable iff (reset)
      !tick |=> ($stable(level) || $fell(filter_on) || !$past(filter_on)))
      else $error("output moved without tick");

   // The image is the filter output one edge later
   a_image_follow : assert property (@(posedge ref_clk) disable iff (reset)
      1'b1 |=> in_image == $past(level))
      else $error("image lag wrong");

   // A mode write is in force on the next edge
   a_mode_write : assert property (@(posedge ref_clk) disable iff (reset)
      s_mode_write |=> (mode_reg == $past(reg_wr.data)))
      else $error("mode write lost");

   // A config write lands in its own word
   a_cfg_write : assert property (@(posedge ref_clk) disable iff (reset)
      s_cfg_write |=> (cfg_reg[$past(wr_idx)] == $past(reg_wr.data)))
      else $error("config write lost");

   // Without a write the mode word holds
   a_mode_hold : assert property (@(posedge ref_clk) disable iff (reset)
      !wr_mode |=> $stable(mode_reg))
      else $error("mode word moved");

   // The tick is a single-cycle enable
   a_tick_single : assert property (@(posedge ref_clk) disable iff (reset)
      tick |=> !tick)
      else $error("tick longer than one cycle");

   // Mode readback one cycle after select
   a_read_mode : assert property (@(posedge ref_clk) disable iff (reset)
      s_read_mode |=> (rd_data == $past(mode_reg)))
      else $error("mode readback wrong");

   // Config readback one cycle after select
   a_read_cfg : assert property (@(posedge ref_clk) disable iff (reset)
      s_read_cfg |=> (rd_data == $past(cfg_reg[rd_idx])))
      else $error("config readback wrong");

   // Unmapped selects read zero
   a_read_unmapped : assert property (@(posedge ref_clk) disable iff (reset)
      ((rd_sel != SEL_MODE) && !cfg_hit(rd_sel)) |=> (rd_data == 16'h0000))
      else $error("unmapped readback not zero");

   // Pins pass exactly two flops before the filters see them
   a_sync_delay : assert property (@(posedge ref_clk) disable iff (reset)
      (!$past(reset) && !$past(reset, 2)) |-> (sync_reg == $past(in_point, 2)))
      else $error("synchroniser depth wrong");

   // With filtering off no filter output stays high
   a_disabled_level : assert property (@(posedge ref_clk) disable iff (reset)
      !filter_on |=> (level == '0))
      else $error("filter active outside filter mode");
endmodule // four_channel_input_filter
`default_nettype wire
